// ---- cp_pkg.sv ----
/*
 * shared constants, field layouts and carrier types of the channel processor.
 * assumes a single 10 MHz clock domain; no module here.
 */
`default_nettype none

package cp_pkg;
    // apb register map (byte addresses)
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_INFO = 12'h00C;
    localparam logic [11:0] ADDR_POST = 12'h010;
    localparam logic [3:0]  PMEM_PAGE = 4'h1;
    localparam logic [4:0]  CODE_PAGE = 5'h04;

    localparam int CODE_WORDS = 32;
    localparam int PMEM_WORDS = 64;
    localparam int NCHAN      = 8;

    // control register
    localparam int          CTRL_MODEL_LSB = 0;
    localparam int          CTRL_RUN_BIT   = 2;
    localparam logic [2:0]  CTRL_RST       = 3'h0;

    // status and mask registers
    localparam int          STAT_DONE_BIT = 0;
    localparam int          STAT_DIS_BIT  = 1;
    localparam logic [1:0]  STAT_RST      = 2'h0;
    localparam logic [1:0]  MASK_RST      = 2'h0;

    // info register
    localparam int INFO_CHAN_LSB = 0;
    localparam int INFO_BUSY_BIT = 3;
    localparam int INFO_SPN_LSB  = 8;
    localparam logic [7:0] SPN_RST = 8'h00;

    // context models, strides in bytes, first saved register
    localparam logic [1:0] MODEL_FULL  = 2'h0;
    localparam logic [1:0] MODEL_SMALL = 2'h1;
    localparam logic [1:0] MODEL_MIN   = 2'h2;
    localparam logic [7:0] STRIDE_FULL  = 8'h20;
    localparam logic [7:0] STRIDE_SMALL = 8'h10;
    localparam logic [7:0] STRIDE_MIN   = 8'h08;
    localparam logic [2:0] FIRST_FULL  = 3'h0;
    localparam logic [2:0] FIRST_SMALL = 3'h4;
    localparam logic [2:0] FIRST_MIN   = 3'h6;

    // register 6 and register 7 fields
    localparam int SPN_LSB = 0;
    localparam int SPN_W   = 8;
    localparam int CNT_LSB = 8;
    localparam int CNT_W   = 16;
    localparam int CEN_BIT = 0;
    localparam int PC_LSB  = 8;
    localparam int PC_W    = 5;

    // opcodes
    localparam logic [3:0] OP_NOP  = 4'h0;
    localparam logic [3:0] OP_LDI  = 4'h1;
    localparam logic [3:0] OP_JIA  = 4'h2;
    localparam logic [3:0] OP_JIR  = 4'h3;
    localparam logic [3:0] OP_ADDI = 4'h4;
    localparam logic [3:0] OP_COPY = 4'h5;
    localparam logic [3:0] OP_EXIT = 4'h6;
    localparam logic [3:0] OP_JMP  = 4'h7;
    localparam logic [3:0] OP_MOV  = 4'h8;

    // condition codes
    localparam logic [1:0] CC_ALWAYS = 2'h0;
    localparam logic [1:0] CC_ZERO   = 2'h1;
    localparam logic [1:0] CC_NZ     = 2'h2;
    localparam logic [1:0] COUNT_NONZERO_CONDITION    = 2'h3;

    // exit and copy immediate fields
    localparam int EX_INT_BIT  = 0;
    localparam int EX_POST_BIT = 1;
    localparam int EX_CHAN_LSB = 2;
    localparam int CP_SRC_LSB  = 0;
    localparam int CP_DST_LSB  = 2;
    localparam int CP_LEN_LSB  = 4;
    localparam logic [1:0]  PTR_KEEP = 2'h0;
    localparam logic [1:0]  PTR_INC  = 2'h1;
    localparam logic [1:0]  PTR_DEC  = 2'h2;
    localparam logic [31:0] PTR_STEP = 32'h00000004;

    typedef struct packed {
        logic [3:0]  op;
        logic [2:0]  ra;
        logic [2:0]  rb;
        logic [1:0]  cc;
        logic [3:0]  spare;
        logic [15:0] imm;
    } cp_instr_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cp_dma_t;

    localparam cp_dma_t DMA_IDLE = '0;
endpackage

`default_nettype wire

// ---- cp_arbiter.sv ----
/*
 * request arbiter: picks the highest pending channel number.
 * assumes channel 0 never carries a request; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module cp_arbiter (
    input  wire logic [7:0] pend,
    output logic            grant_valid,
    output logic [2:0]      grant_chan
);
    always_comb begin
        grant_valid = 1'b0;
        grant_chan  = 3'h0;
        for (int i = 1; i < cp_pkg::NCHAN; i++) begin
            if (pend[i]) begin
                grant_valid = 1'b1;
                grant_chan  = 3'(i);
            end
        end
    end
endmodule

`default_nettype wire

// ---- cp_channel_processor.sv ----
/*
 * channel processor core: context switch, channel program execution,
 * block transfer master, apb register slave and host interrupt.
 * assumes peripherals drive asynchronous request pins and the system
 * memory answers dma requests on the same clock with a one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none

module cp_channel_processor (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [7:0]      periph_req,
    output cp_pkg::cp_dma_t      dma,
    input  wire logic [31:0]     dma_rdata,
    input  wire logic            dma_ack,
    output logic                 irq
);
    typedef enum logic [2:0] {
        S_IDLE, S_LOAD, S_CHECK, S_EXEC, S_RD, S_WR, S_SAVE
    } cp_state_t;

    ////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [2:0] ctx_first(input logic [1:0] m);
        if (m == cp_pkg::MODEL_SMALL) begin
            return cp_pkg::FIRST_SMALL;
        end else if (m == cp_pkg::MODEL_MIN) begin
            return cp_pkg::FIRST_MIN;
        end
        return cp_pkg::FIRST_FULL;
    endfunction

    function automatic logic [7:0] ctx_stride(input logic [1:0] m);
        if (m == cp_pkg::MODEL_SMALL) begin
            return cp_pkg::STRIDE_SMALL;
        end else if (m == cp_pkg::MODEL_MIN) begin
            return cp_pkg::STRIDE_MIN;
        end
        return cp_pkg::STRIDE_FULL;
    endfunction

    // word index of context slot i of channel c
    function automatic logic [5:0] ctx_addr(input logic [1:0] m, input logic [2:0] c,
                                            input logic [2:0] i);
        logic [7:0] words;
        words = ctx_stride(m) >> 2;
        return 6'(c * words + 8'(i));
    endfunction

    function automatic logic cond_ok(input logic [1:0] cc, input logic [31:0] v,
                                     input logic [15:0] cnt);
        case (cc)
            cp_pkg::CC_ZERO: return v == 32'h00000000;
            cp_pkg::CC_NZ:   return v != 32'h00000000;
            cp_pkg::COUNT_NONZERO_CONDITION:  return cnt != 16'h0000;
            default:         return 1'b1;
        endcase
    endfunction

    function automatic logic [31:0] ptr_step(input logic [31:0] p, input logic [1:0] md);
        if (md == cp_pkg::PTR_INC) begin
            return p + cp_pkg::PTR_STEP;
        end else if (md == cp_pkg::PTR_DEC) begin
            return p - cp_pkg::PTR_STEP;
        end
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // storage

    cp_state_t       state_r;
    logic [31:0]     gpr_r  [8];
    logic [31:0]     code_r [cp_pkg::CODE_WORDS];
    logic [31:0]     pmem_r [cp_pkg::PMEM_WORDS];
    logic [4:0]      pc_r;
    logic [2:0]      chan_r;
    logic [2:0]      cnt_r;
    logic [2:0]      bcnt_r;
    cp_pkg::cp_dma_t dma_r;
    logic [2:0]      ctrl_r;
    logic [1:0]      stat_r;
    logic [1:0]      mask_r;
    logic [7:0]      spn_r;
    logic [7:0]      pend_r;
    logic [7:0]      req_s1_r;
    logic [7:0]      req_s2_r;
    logic [7:0]      req_d_r;
    logic [31:0]     prdata_r;
    logic            pready_r;
    logic            pslverr_r;
    logic            irq_r;

    ////////////////////////////////////////////////////////////////////
    // decode

    cp_pkg::cp_instr_t ins;
    wire logic [1:0]   model    = ctrl_r[cp_pkg::CTRL_MODEL_LSB +: 2];
    wire logic         run      = ctrl_r[cp_pkg::CTRL_RUN_BIT];
    wire logic [2:0]   first    = ctx_first(model);
    wire logic [2:0]   last_idx = 3'(3'h7 - first);
    wire logic [5:0]   cidx     = ctx_addr(model, chan_r, cnt_r);
    wire logic [2:0]   creg     = 3'(first + cnt_r);
    wire logic [15:0]  tcount   = gpr_r[6][cp_pkg::CNT_LSB +: cp_pkg::CNT_W];
    wire logic [31:0]  va       = gpr_r[ins.ra];
    wire logic [31:0]  vb       = gpr_r[ins.rb];
    wire logic         cok      = cond_ok(ins.cc, vb, tcount);
    wire logic [4:0]   pc_inc   = 5'(pc_r + 5'h01);
    wire logic [1:0]   src_md   = ins.imm[cp_pkg::CP_SRC_LSB +: 2];
    wire logic [1:0]   dst_md   = ins.imm[cp_pkg::CP_DST_LSB +: 2];
    wire logic         in_exec  = state_r == S_EXEC;
    wire logic         is_exit  = in_exec && ins.op == cp_pkg::OP_EXIT;
    // count-nonzero exit fires once the counter has run out
    wire logic         exit_cnd = (ins.cc == cp_pkg::COUNT_NONZERO_CONDITION) ? !cok : cok;
    wire logic         ev_done  = is_exit && ins.imm[cp_pkg::EX_INT_BIT] && exit_cnd;
    wire logic         ev_post  = is_exit && ins.imm[cp_pkg::EX_POST_BIT];
    wire logic [2:0]   post_ch  = ins.imm[cp_pkg::EX_CHAN_LSB +: 3];
    wire logic         ev_dis   = state_r == S_CHECK && !gpr_r[7][cp_pkg::CEN_BIT];
    wire logic         burst_end = state_r == S_WR && dma_ack && bcnt_r == 3'h0;

    assign ins = cp_pkg::cp_instr_t'(code_r[pc_r]);

    ////////////////////////////////////////////////////////////////////
    // arbitration and pending requests

    logic       grant_valid;
    logic [2:0] grant_chan;

    cp_arbiter u_arb (
        .pend        (pend_r),
        .grant_valid (grant_valid),
        .grant_chan  (grant_chan)
    );

    wire logic       take     = state_r == S_IDLE && run && grant_valid;
    wire logic [7:0] take_vec = take ? 8'(8'h01 << grant_chan) : 8'h00;
    wire logic [7:0] rise_vec = req_s2_r & ~req_d_r;
    wire logic [7:0] post_vec = ev_post ? 8'(8'h01 << post_ch) : 8'h00;

    ////////////////////////////////////////////////////////////////////
    // apb decode

    wire logic apb_acc   = psel && penable;
    wire logic apb_wr    = apb_acc && pready_r && pwrite;
    wire logic hit_ctrl  = paddr == cp_pkg::ADDR_CTRL;
    wire logic hit_stat  = paddr == cp_pkg::ADDR_STAT;
    wire logic hit_mask  = paddr == cp_pkg::ADDR_MASK;
    wire logic hit_info  = paddr == cp_pkg::ADDR_INFO;
    wire logic hit_post  = paddr == cp_pkg::ADDR_POST;
    wire logic hit_pmem  = paddr[11:8] == cp_pkg::PMEM_PAGE && paddr[1:0] == 2'h0;
    wire logic hit_code  = paddr[11:7] == cp_pkg::CODE_PAGE && paddr[1:0] == 2'h0;
    wire logic [5:0] pm_idx = paddr[7:2];
    wire logic [4:0] cd_idx = paddr[6:2];
    wire logic [1:0] w1c     = (apb_wr && hit_stat) ? pwdata[1:0] : 2'h0;
    wire logic [7:0] host_vec = (apb_wr && hit_post) ? pwdata[7:0] : 8'h00;
    wire logic [1:0] ev_vec  = {ev_dis, ev_done};

    logic [31:0] rd_val;
    logic        rd_bad;

    // general registers have no bus address
    always_comb begin
        rd_val = 32'h00000000;
        rd_bad = 1'b0;
        if (hit_ctrl) begin
            rd_val[2:0] = ctrl_r;
        end else if (hit_stat) begin
            rd_val[1:0] = stat_r;
        end else if (hit_mask) begin
            rd_val[1:0] = mask_r;
        end else if (hit_info) begin
            rd_val[cp_pkg::INFO_CHAN_LSB +: 3] = chan_r;
            rd_val[cp_pkg::INFO_BUSY_BIT]      = state_r != S_IDLE;
            rd_val[cp_pkg::INFO_SPN_LSB +: 8]  = spn_r;
        end else if (hit_post) begin
            rd_val[7:0] = pend_r;
        end else if (hit_pmem) begin
            rd_val = pmem_r[pm_idx];
        end else if (hit_code) begin
            rd_val = code_r[cd_idx];
        end else begin
            rd_bad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave and host-side registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
            ctrl_r    <= cp_pkg::CTRL_RST;
            mask_r    <= cp_pkg::MASK_RST;
            stat_r    <= cp_pkg::STAT_RST;
            irq_r     <= 1'b0;
        end else begin
            pready_r  <= apb_acc && !pready_r;
            pslverr_r <= apb_acc && !pready_r && rd_bad;
            prdata_r  <= (apb_acc && !pready_r && !pwrite) ? rd_val : 32'h00000000;
            if (apb_wr && hit_ctrl) begin
                ctrl_r <= pwdata[2:0];
            end
            if (apb_wr && hit_mask) begin
                mask_r <= pwdata[1:0];
            end
            stat_r <= (stat_r & ~w1c) | ev_vec;
            irq_r  <= |(((stat_r & ~w1c) | ev_vec) & mask_r);
        end
    end

    always_ff @(posedge pclk) begin
        if (apb_wr && hit_code) begin
            code_r[cd_idx] <= pwdata;
        end
    end

    // core save has priority over any host pmem write in the same cycle
    always_ff @(posedge pclk) begin
        if (state_r == S_SAVE) begin
            pmem_r[cidx] <= gpr_r[creg];
        end else if (apb_wr && hit_pmem) begin
            pmem_r[pm_idx] <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request pins and pending set

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_s1_r <= 8'h00;
            req_s2_r <= 8'h00;
            req_d_r  <= 8'h00;
            pend_r   <= 8'h00;
            spn_r    <= cp_pkg::SPN_RST;
        end else begin
            req_s1_r <= periph_req;
            req_s2_r <= req_s1_r;
            req_d_r  <= req_s2_r;
            pend_r   <= (pend_r & ~take_vec) | rise_vec | post_vec | host_vec;
            if (ev_done) begin
                spn_r <= gpr_r[6][cp_pkg::SPN_LSB +: cp_pkg::SPN_W];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // channel sequencer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            pc_r    <= 5'h00;
            chan_r  <= 3'h0;
            cnt_r   <= 3'h0;
            bcnt_r  <= 3'h0;
            dma_r   <= cp_pkg::DMA_IDLE;
            for (int i = 0; i < 8; i++) begin
                gpr_r[i] <= 32'h00000000;
            end
        end else begin
            case (state_r)
                S_IDLE: begin
                    cnt_r <= 3'h0;
                    if (take) begin
                        chan_r  <= grant_chan;
                        state_r <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    // only the model's subset is reloaded
                    gpr_r[creg] <= pmem_r[cidx];
                    cnt_r       <= 3'(cnt_r + 3'h1);
                    if (cnt_r == last_idx) begin
                        state_r <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    cnt_r <= 3'h0;
                    pc_r  <= gpr_r[7][cp_pkg::PC_LSB +: cp_pkg::PC_W];
                    if (ev_dis) begin
                        state_r <= S_IDLE;
                    end else begin
                        state_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    pc_r <= pc_inc;
                    case (ins.op)
                        cp_pkg::OP_LDI: begin
                            gpr_r[ins.rb] <= {16'h0000, ins.imm};
                        end
                        cp_pkg::OP_MOV: begin
                            gpr_r[ins.rb] <= va;
                        end
                        cp_pkg::OP_ADDI: begin
                            gpr_r[ins.rb] <= vb + {16'h0000, ins.imm};
                        end
                        cp_pkg::OP_JMP: begin
                            pc_r <= ins.imm[4:0];
                        end
                        cp_pkg::OP_JIA: begin
                            pc_r <= va[4:0];
                        end
                        cp_pkg::OP_JIR: begin
                            if (cok) begin
                                pc_r <= 5'(pc_inc + va[4:0]);
                            end
                        end
                        cp_pkg::OP_COPY: begin
                            pc_r       <= pc_r;
                            bcnt_r     <= ins.imm[cp_pkg::CP_LEN_LSB +: 3];
                            dma_r.req  <= 1'b1;
                            dma_r.we   <= 1'b0;
                            dma_r.addr <= gpr_r[4];
                            state_r    <= S_RD;
                        end
                        cp_pkg::OP_EXIT: begin
                            gpr_r[7][cp_pkg::PC_LSB +: cp_pkg::PC_W] <= pc_inc;
                            cnt_r   <= 3'h0;
                            state_r <= S_SAVE;
                        end
                        default: begin
                        end
                    endcase
                end
                S_RD: begin
                    if (dma_ack) begin
                        gpr_r[4]    <= ptr_step(gpr_r[4], src_md);
                        dma_r.we    <= 1'b1;
                        dma_r.addr  <= gpr_r[5];
                        dma_r.wdata <= dma_rdata;
                        state_r     <= S_WR;
                    end
                end
                S_WR: begin
                    if (dma_ack) begin
                        gpr_r[5]   <= ptr_step(gpr_r[5], dst_md);
                        dma_r.we   <= 1'b0;
                        dma_r.addr <= ptr_step(gpr_r[4], cp_pkg::PTR_KEEP);
                        bcnt_r     <= 3'(bcnt_r - 3'h1);
                        state_r    <= S_RD;
                        if (burst_end) begin
                            gpr_r[6][cp_pkg::CNT_LSB +: cp_pkg::CNT_W] <=
                                16'(tcount - 16'h0001);
                            dma_r   <= cp_pkg::DMA_IDLE;
                            pc_r    <= pc_inc;
                            state_r <= S_EXEC;
                        end
                    end
                end
                S_SAVE: begin
                    cnt_r <= 3'(cnt_r + 3'h1);
                    if (cnt_r == last_idx) begin
                        state_r <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign dma     = dma_r;
    assign irq     = irq_r;
endmodule

`default_nettype wire

// ---- cp_asserts.sv ----
/* port assertions of the channel processor.
   assumes one pclk domain; bound to every cp_channel_processor. */
`timescale 1ns/1ps
`default_nettype none
module cp_asserts (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire cp_pkg::cp_dma_t dma,
    input wire logic [31:0]     dma_rdata,
    input wire logic            dma_ack,
    input wire logic            irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic gap = paddr[1:0] != 2'h0 || (paddr > 12'h010 && paddr < 12'h100);
    wire logic rd_ack = dma.req && !dma.we && dma_ack;
    ////////////////////////////////////////
    chk_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    chk_gap_error: assert property (pready && gap |-> pslverr)
        else $error("no error on unmapped address");
    chk_mem_ok: assert property (pready && !gap && paddr < 12'h280 |-> !pslverr)
        else $error("error on mapped address");
    chk_dma_hold: assert property (dma.req && !dma_ack |=> $stable(dma))
        else $error("dma request changed before ack");
    chk_read_write: assert property (rd_ack |=> dma.req && dma.we)
        else $error("read not followed by write");
    chk_copy_data: assert property (rd_ack |=> dma.wdata == $past(dma_rdata))
        else $error("written word differs from read word");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (dma.req && dma.we && dma_ack);
endmodule
bind cp_channel_processor cp_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma(dma), .dma_rdata(dma_rdata), .dma_ack(dma_ack), .irq(irq));
`default_nettype wire

// ---- cp_mem_model.sv ----
/* system memory answering the block-transfer master.
   assumes one request at a time, ack one or more cycles after req. */
`timescale 1ns/1ps
`default_nettype none
module cp_mem_model (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire cp_pkg::cp_dma_t dma,
    output logic [31:0]          dma_rdata,
    output logic                 dma_ack
);
    logic [31:0] mem [256];
    logic [31:0] wr_cnt;
    logic [1:0]  wait_cnt;
    wire  logic [7:0] idx = dma.addr[9:2];
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ack <= 1'b0;
            dma_rdata <= 32'h0;
            wait_cnt <= 2'h0;
            wr_cnt <= 32'h0;
        end else begin
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata; // data bus not held
            if (dma.req && !dma_ack) begin
                wait_cnt <= wait_cnt + 2'h1;
                if (wait_cnt == dma.addr[3:2]) begin
                    dma_ack <= 1'b1;
                    wait_cnt <= 2'h0;
                    if (dma.we) begin
                        mem[idx] <= dma.wdata;
                        wr_cnt <= wr_cnt + 32'h1;
                    end else dma_rdata <= mem[idx];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test_channel_processor_dma_flow.sv ----
/* self-checking bench: contexts, jumps, block transfer, irq.
   assumes cp_mem_model as system memory and one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module test_channel_processor_dma_flow;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, dma_ack, irq, err;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, dma_rdata, rd;
    logic [31:0]     src_val [8];
    logic [31:0]     seed = 32'h0000_0025;
    logic [7:0]      periph_req;
    cp_pkg::cp_dma_t dma;
    int              mismatches, check_count;
    localparam logic [31:0] PROG [11] = '{32'h1040_0003, 32'h3200_0000, 32'h6000_0000,
        32'h6000_0000, 32'h6000_0000, 32'h1080_0008, 32'h2400_0000, 32'h6000_0000,
        32'h5000_0039, 32'h6030_0017, 32'h7000_0000};
    cp_channel_processor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_req(periph_req), .dma(dma), .dma_rdata(dma_rdata),
        .dma_ack(dma_ack), .irq(irq));
    cp_mem_model i_mem (.pclk(pclk), .presetn(presetn), .dma(dma), .dma_rdata(dma_rdata),
        .dma_ack(dma_ack));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] dst_idx(input int j);
        return 8'hFF - 8'(j);
    endfunction
    task automatic final_report();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("Error pready expected 1 seen %b", pready);
            final_report();
        end
    endtask
    task automatic trig(input int c);
        @(posedge pclk);
        periph_req[c] <= 1'b1;
        repeat (4) @(posedge pclk);
        periph_req[c] <= 1'b0;
    endtask
    task automatic waitw(input logic [31:0] n);
        int k;
        for (k = 0; k < 500 && i_mem.wr_cnt !== n; k++) @(posedge pclk);
        if (k == 500) begin
            mismatches++;
            $display("Error wr_cnt expected %0d seen %0d", n, i_mem.wr_cnt);
            final_report();
        end
        repeat (20) @(posedge pclk);
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; periph_req = 8'h00; mismatches = 0; check_count = 0;
        for (int i = 0; i < 256; i++) begin
            i_mem.mem[i] = xs();
            if (i < 8) src_val[i] = i_mem.mem[i];
        end
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cp_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_rst", {29'h0, cp_pkg::CTRL_RST}, rd);
        apb(1'b0, cp_pkg::ADDR_STAT, 32'h0);
        chk("stat_rst", {30'h0, cp_pkg::STAT_RST}, rd);
        apb(1'b0, cp_pkg::ADDR_MASK, 32'h0);
        chk("mask_rst", {30'h0, cp_pkg::MASK_RST}, rd);
        apb(1'b1, 12'h014, xs());
        chk("unmapped_err", 32'h1, {31'h0, err});
        for (int i = 0; i < 11; i++) apb(1'b1, 12'h200 + 12'(4 * i), PROG[i]);
        apb(1'b1, 12'h130, 32'h0);
        apb(1'b1, 12'h134, 32'h0000_03FC);
        apb(1'b1, 12'h138, 32'h0000_025A);
        apb(1'b1, 12'h13C, 32'h0000_0001);
        apb(1'b1, 12'h15C, 32'h0);
        apb(1'b1, cp_pkg::ADDR_MASK, 32'h1);
        apb(1'b1, cp_pkg::ADDR_CTRL, 32'h5);
        trig(5);
        repeat (30) @(posedge pclk);
        apb(1'b0, cp_pkg::ADDR_STAT, 32'h0);
        chk("stat_disabled", 32'h2, rd);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, cp_pkg::ADDR_STAT, 32'h2);
        trig(3);
        waitw(32'h4);
        chk("burst_len", 32'h4, i_mem.wr_cnt);
        chk("irq_count_left", 32'h0, {31'h0, irq});
        apb(1'b0, cp_pkg::ADDR_STAT, 32'h0);
        chk("stat_post", 32'h2, rd);
        trig(3);
        waitw(32'h8);
        chk("irq_done", 32'h1, {31'h0, irq});
        for (int j = 0; j < 8; j++) chk("dst_word", src_val[j], i_mem.mem[dst_idx(j)]);
        apb(1'b0, cp_pkg::ADDR_INFO, 32'h0);
        chk("info_spn", 32'h5A, {24'h0, rd[15:8]});
        chk("info_chan", 32'h5, {29'h0, rd[2:0]});
        apb(1'b1, cp_pkg::ADDR_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_off_mask", 32'h0, {31'h0, irq});
        apb(1'b1, cp_pkg::ADDR_MASK, 32'h1);
        apb(1'b1, cp_pkg::ADDR_STAT, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        apb(1'b0, cp_pkg::ADDR_STAT, 32'h0);
        chk("stat_cleared", 32'h0, rd);
        final_report();
    end
endmodule
`default_nettype wire
